// [hw/csr_device.sv]
/*
  Charger bus register slave: answers word-write and word-read transactions at one
  address, holds the option, current, voltage and identity registers, and runs the
  adapter deglitch and the charge watchdog.
  Assumes the host keeps to standard two-wire timing, with SCL high/low phases of many pclk.
*/
// The APB register port is this design's own decision.
// Functional notes
// - Slave only, one fixed address.
// - Only word-write and word-read transactions.
// - Ignore bus unless supply and adapter good.
// - Bytes MSB first, sampled on SCL rise.
// - Nine pulses per byte, receiver acknowledges.
// - SDA changes only while SCL low.
// - Master frames transfers with start, stop.
// - Word write: address, command, low, high.
// - Word read: repeated start, low, high, NACK.
// - Six command codes decoded.
// - Field widths 7, 11, 6 bits.
// - Power-on defaults for all registers.
// - Identity registers constant, writes ignored.
// - Option register writable, reads back.
// - Option bit 15 picks deglitch delay.
// - Option bits 14:13 pick watchdog period.
// - No current/voltage write in period suspends.
// - Next current/voltage write resumes charging.
// - Option bit 0 inhibits charging.
// - Out-of-range current clears register, stops.
module csr_device #(
  parameter longint WDOG_44_CYC  = csr_pkg::WDOG_44_CYC,
  parameter longint WDOG_88_CYC  = csr_pkg::WDOG_88_CYC,
  parameter longint WDOG_175_CYC = csr_pkg::WDOG_175_CYC,
  parameter longint DEGLITCH_CYC = csr_pkg::DEGLITCH_LONG_CYC,
  parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value.
  parameter logic [15:0] PART_ID  = 16'h0001  // Arbitrary value.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  csr_link_if.device       link,
  input  wire logic        supply_ok,
  input  wire logic        adapter_detect_input,
  output logic             adapter_valid_flag,
  output logic             charge_enable,
  output logic [15:0]      charger_option_control,
  output logic [15:0]      charge_current_setting,
  output logic [15:0]      charge_voltage_setting,
  output logic [15:0]      input_current_setting
);
  typedef enum logic [2:0] {
    CSR_IDLE  = 3'b000,
    CSR_RECV  = 3'b001,
    CSR_ACK   = 3'b010,
    CSR_SEND  = 3'b011,
    CSR_MACK  = 3'b100,
    CSR_WAIT  = 3'b101
  } csr_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and line event detection.
  logic [1:0] scl_sync, sda_sync, sup_sync, det_sync;
  logic       scl_d, sda_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sup_sync <= 2'h0;
      det_sync <= 2'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      sup_sync <= {sup_sync[0], supply_ok};
      det_sync <= {det_sync[0], adapter_detect_input};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end
  wire scl_s     = scl_sync[1];
  wire sda_s     = sda_sync[1];
  wire bus_on    = sup_sync[1] && det_sync[1];
  wire scl_rise  = scl_s && !scl_d;
  wire scl_fall  = !scl_s && scl_d;
  wire start_ev  = scl_s && scl_d && sda_d && !sda_s;
  wire stop_ev   = scl_s && scl_d && !sda_d && sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Transaction engine.
  csr_state_type state;
  logic [7:0]  shreg;
  logic [3:0]  bitcnt;
  logic [1:0]  bytenum;   // 0 address, 1 command, 2 low data, 3 high data
  logic        reading;
  logic        sda_oe;
  logic [7:0]  command;
  logic [7:0]  low_byte;
  logic [15:0] rd_word;
  logic        hi_sent;
  logic        wr_pulse;
  logic [15:0] wr_word;

  wire cmd_known = shreg == csr_pkg::CMD_OPTION || shreg == csr_pkg::CMD_CHG_CURRENT
                || shreg == csr_pkg::CMD_CHG_VOLTAGE || shreg == csr_pkg::CMD_INPUT_CURRENT
                || shreg == csr_pkg::CMD_MAKER_ID || shreg == csr_pkg::CMD_PART_ID;
  wire addr_hit  = shreg[7:1] == csr_pkg::SLAVE_ADDR;
  wire read_ok   = bytenum == 2'd0 && addr_hit && shreg[0] && command != 8'h00;
  wire ack_now   = bytenum == 2'd0 ? addr_hit && (!shreg[0] || read_ok)
                 : bytenum == 2'd1 ? cmd_known
                 : 1'b1;
  always_comb begin
    case (command)
      csr_pkg::CMD_OPTION:        rd_word = charger_option_control;
      csr_pkg::CMD_CHG_CURRENT:   rd_word = charge_current_setting;
      csr_pkg::CMD_CHG_VOLTAGE:   rd_word = charge_voltage_setting;
      csr_pkg::CMD_INPUT_CURRENT: rd_word = input_current_setting;
      csr_pkg::CMD_MAKER_ID:      rd_word = MAKER_ID;
      csr_pkg::CMD_PART_ID:       rd_word = PART_ID;
      default:                    rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= CSR_IDLE;
      shreg    <= 8'h00;
      bitcnt   <= 4'h0;
      bytenum  <= 2'd0;
      reading  <= 1'b0;
      sda_oe   <= 1'b0;
      command  <= 8'h00;
      low_byte <= 8'h00;
      hi_sent  <= 1'b0;
      wr_pulse <= 1'b0;
      wr_word  <= 16'h0000;
    end else begin
      wr_pulse <= 1'b0;
      if (!bus_on || stop_ev) begin
        state  <= CSR_IDLE;
        sda_oe <= 1'b0;
        if (stop_ev) command <= 8'h00;
      end else if (start_ev) begin
        state   <= CSR_RECV;
        bitcnt  <= 4'h0;
        bytenum <= 2'd0;
        reading <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          CSR_RECV: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              sda_oe <= ack_now;
              state  <= ack_now ? CSR_ACK : CSR_WAIT;
              if (bytenum == 2'd1) command <= shreg;
              if (bytenum == 2'd2) low_byte <= shreg;
              if (bytenum == 2'd3) begin
                wr_word  <= {shreg, low_byte};
                wr_pulse <= 1'b1;
              end
              if (bytenum == 2'd0) reading <= shreg[0];
            end
          end
          CSR_ACK: begin
            if (scl_fall) begin
              bitcnt  <= 4'h0;
              hi_sent <= 1'b0;
              if (reading) begin
                state  <= CSR_SEND;
                shreg  <= rd_word[7:0];
                sda_oe <= !rd_word[7];
              end else begin
                sda_oe  <= 1'b0;
                bytenum <= bytenum + 2'd1;
                state   <= bytenum == 2'd3 ? CSR_WAIT : CSR_RECV;
              end
            end
          end
          CSR_SEND: begin
            if (scl_rise) bitcnt <= bitcnt + 4'h1;
            else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state  <= CSR_MACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                sda_oe <= !shreg[6];
              end
            end
          end
          CSR_MACK: begin
            if (scl_rise) begin
              if (sda_s || hi_sent) state <= CSR_WAIT;
              else begin
                hi_sent <= 1'b1;
                bitcnt  <= 4'h0;
                shreg   <= rd_word[15:8];
              end
            end else if (scl_fall && hi_sent && state == CSR_MACK) begin
              state  <= CSR_SEND;
              sda_oe <= !shreg[7];
            end
          end
          CSR_WAIT: sda_oe <= 1'b0;
          default:  state  <= CSR_IDLE;
        endcase
      end
    end
  end
  assign link.sda_oe_dev = sda_oe;
  assign link.scl_oe_dev = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bank.
  wire wr_opt = wr_pulse && command == csr_pkg::CMD_OPTION;
  wire wr_cc  = wr_pulse && command == csr_pkg::CMD_CHG_CURRENT;
  wire wr_cv  = wr_pulse && command == csr_pkg::CMD_CHG_VOLTAGE;
  wire wr_ic  = wr_pulse && command == csr_pkg::CMD_INPUT_CURRENT;
  wire cc_bad = wr_word < csr_pkg::CHG_CURRENT_MIN || wr_word > csr_pkg::CHG_CURRENT_MAX;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_option_control <= csr_pkg::OPTION_RESET;
      charge_current_setting <= csr_pkg::CHG_CURRENT_RESET;
      charge_voltage_setting <= csr_pkg::CHG_VOLTAGE_RESET;
      input_current_setting  <= csr_pkg::INPUT_CURRENT_RESET;
    end else begin
      if (wr_opt) charger_option_control <= wr_word;
      if (wr_cc) charge_current_setting <= cc_bad ? 16'h0000 : wr_word & csr_pkg::CHG_CURRENT_MASK;
      if (wr_cv) charge_voltage_setting <= wr_word & csr_pkg::CHG_VOLTAGE_MASK;
      if (wr_ic) input_current_setting  <= wr_word & csr_pkg::INPUT_CURRENT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog and adapter deglitch. Counters are 32 bits; 175 s at 10 MHz fits.
  logic [31:0] wd_cnt, dg_cnt;
  logic        wd_expired;
  wire  [1:0]  wd_sel = charger_option_control[csr_pkg::OPT_WDOG_LSB +: 2];
  wire  [31:0] wd_limit = wd_sel == 2'b01 ? 32'(WDOG_44_CYC)
                        : wd_sel == 2'b10 ? 32'(WDOG_88_CYC) : 32'(WDOG_175_CYC);
  wire  [31:0] dg_limit = charger_option_control[csr_pkg::OPT_DEGLITCH_BIT]
                        ? 32'(csr_pkg::DEGLITCH_SHORT_CYC) : 32'(DEGLITCH_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt             <= 32'h0;
      wd_expired         <= 1'b0;
      dg_cnt             <= 32'h0;
      adapter_valid_flag <= 1'b0;
    end else begin
      if (wr_cc || wr_cv || wd_sel == 2'b00) begin
        wd_cnt     <= 32'h0;
        wd_expired <= 1'b0;
      end else if (wd_cnt >= wd_limit - 32'h1) begin
        wd_expired <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
      if (!det_sync[1]) begin
        dg_cnt             <= 32'h0;
        adapter_valid_flag <= 1'b0;
      end else if (dg_cnt >= dg_limit) begin
        adapter_valid_flag <= 1'b1;
      end else begin
        dg_cnt <= dg_cnt + 32'h1;
      end
    end
  end
  assign charge_enable = !charger_option_control[csr_pkg::OPT_INHIBIT_BIT]
                      && !wd_expired && adapter_valid_flag
                      && charge_current_setting != 16'h0000
                      && charge_voltage_setting != 16'h0000
                      && input_current_setting != 16'h0000;
endmodule // csr_device

// [hw/csr_host.sv]
/*
  Bus master for the charger register slave: software programs command, direction and
  word over APB; the host runs one word-write or word-read on the two-wire link.
  Assumes the slave never stretches the clock.
*/
module csr_host #(
  parameter int DIV = csr_pkg::HOST_CLK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  csr_link_if.host         link
);
  typedef enum logic [1:0] {
    CSH_IDLE = 2'b00,
    CSH_RUN  = 2'b01
  } csh_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] sda_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sda_sync <= 2'h3;
    else          sda_sync <= {sda_sync[0], link.sda};
  end

  csh_state_type state;
  logic [7:0]  cmd;
  logic        rd;
  logic [15:0] wdata, rdata;
  logic        nack_seen, done;
  logic [5:0]  slot;      // 0 start, bits/acks, stop sequence follows
  logic [1:0]  phase;
  logic [7:0]  div;
  logic [3:0]  bitn;
  logic [2:0]  byten;     // Byte index within the frame.
  logic [7:0]  txb;
  logic        scl_low, sda_low;

  wire access  = psel && penable;
  wire wr_ctrl = access && pwrite && paddr == csr_pkg::HREG_CTRL && state == CSH_IDLE;
  wire wr_wd   = access && pwrite && paddr == csr_pkg::HREG_WDATA;
  wire known   = paddr == csr_pkg::HREG_CTRL || paddr == csr_pkg::HREG_WDATA
              || paddr == csr_pkg::HREG_STATUS || paddr == csr_pkg::HREG_RDATA;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
  always_comb begin
    case (paddr)
      csr_pkg::HREG_CTRL:   prdata = {23'h0, rd, cmd};
      csr_pkg::HREG_WDATA:  prdata = {16'h0, wdata};
      csr_pkg::HREG_STATUS: prdata = {29'h0, nack_seen, done, state == CSH_RUN};
      csr_pkg::HREG_RDATA:  prdata = {16'h0, rdata};
      default:              prdata = 32'h0;
    endcase
  end

  // Byte plan: write 0 addr/W,1 cmd,2 lo,3 hi; read 0 addr/W,1 cmd,2 addr/R (after restart),3 lo,4 hi.
  wire [2:0] last_byte = rd ? 3'd4 : 3'd3;
  wire       rx_byte   = rd && byten >= 3'd3;
  always_comb begin
    case (byten)
      3'd0:    txb = {csr_pkg::SLAVE_ADDR, 1'b0};
      3'd1:    txb = cmd;
      3'd2:    txb = rd ? {csr_pkg::SLAVE_ADDR, 1'b1} : wdata[7:0];
      3'd3:    txb = wdata[15:8];
      default: txb = 8'hff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each bit is four quarter periods of DIV pclk: low/low/high/high on SCL.
  wire tick = div == 8'(DIV - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CSH_IDLE; cmd <= 8'h00; rd <= 1'b0; wdata <= 16'h0; rdata <= 16'h0;
      nack_seen <= 1'b0; done <= 1'b0; slot <= 6'h0; phase <= 2'h0; div <= 8'h0;
      bitn <= 4'h0; byten <= 3'd0; scl_low <= 1'b0; sda_low <= 1'b0;
    end else begin
      if (wr_wd) wdata <= pwdata[15:0];
      if (wr_ctrl) begin
        cmd <= pwdata[7:0]; rd <= pwdata[8]; state <= CSH_RUN; done <= 1'b0;
        nack_seen <= 1'b0; slot <= 6'h0; phase <= 2'h0; div <= 8'h0; bitn <= 4'h0; byten <= 3'd0;
        // Start: SDA falls while SCL is still high.
        sda_low <= 1'b1;
      end else if (state == CSH_RUN) begin
        div <= tick ? 8'h0 : div + 8'h1;
        if (tick) begin
          phase <= phase + 2'h1;
          if (slot == 6'h0) begin
            if (phase == 2'h1) begin scl_low <= 1'b1; slot <= 6'h1; phase <= 2'h0; end
          end else if (slot == 6'h2) begin
            // Stop or repeated start sequence.
            case (phase)
              2'h0: sda_low <= (byten == 3'd2 && rd) ? 1'b0 : 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= (byten == 3'd2 && rd) ? 1'b1 : 1'b0;
              default: begin
                if (byten == 3'd2 && rd) begin scl_low <= 1'b1; slot <= 6'h1; phase <= 2'h0; end
                else begin state <= CSH_IDLE; done <= 1'b1; slot <= 6'h0; end
              end
            endcase
          end else begin
            case (phase)
              2'h0: begin
                if (bitn < 4'h8) sda_low <= rx_byte ? 1'b0 : !txb[3'(7 - bitn)];
                else sda_low <= rx_byte ? (byten == 3'd3) : 1'b0;  // Master acks low, NACKs high.
              end
              2'h1: scl_low <= 1'b0;
              2'h2: begin
                if (bitn < 4'h8 && rx_byte) rdata <= byten == 3'd3 ? {rdata[15:8], rdata[6:0], sda_sync[1]}
                                                                 : {rdata[14:8], sda_sync[1], rdata[7:0]};
                if (bitn == 4'h8 && !rx_byte && sda_sync[1]) nack_seen <= 1'b1;
              end
              default: begin
                scl_low <= 1'b1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  if (nack_seen || byten == last_byte || (rd && byten == 3'd1)) begin
                    slot <= 6'h2;
                    if (!(rd && byten == 3'd1) || nack_seen) byten <= 3'd7;
                  end
                  byten <= (nack_seen || byten == last_byte) ? 3'd7 : byten + 3'd1;
                end else bitn <= bitn + 4'h1;
              end
            endcase
          end
        end
      end
    end
  end
  assign link.scl_oe_host = scl_low;
  assign link.sda_oe_host = sda_low;
endmodule // csr_host

// [hw/csr_link_if.sv]
/*
  Two-wire link between the charger register slave and its host.
  Both lines are open drain with pull-up: a line is low if any end enables its driver.
*/
interface csr_link_if;
  logic scl_oe_dev;
  logic sda_oe_dev;
  logic scl_oe_host;
  logic sda_oe_host;
  logic scl;
  logic sda;
  assign scl = !(scl_oe_dev || scl_oe_host);
  assign sda = !(sda_oe_dev || sda_oe_host);
  modport device (input scl, input sda, output scl_oe_dev, output sda_oe_dev);
  modport host   (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

// [hw/csr_pkg.sv]
/*
  Package for the charger bus register slave and its host controller: command codes,
  reset values, option field positions, bus address and timing counts.
  Assumes a 10 MHz pclk shared by both ends.
*/
package csr_pkg;
  localparam logic [6:0]  SLAVE_ADDR          = 7'h09;
  localparam logic [7:0]  CMD_OPTION          = 8'h12;
  localparam logic [7:0]  CMD_CHG_CURRENT     = 8'h14;
  localparam logic [7:0]  CMD_CHG_VOLTAGE     = 8'h15;
  localparam logic [7:0]  CMD_INPUT_CURRENT   = 8'h3f;
  localparam logic [7:0]  CMD_MAKER_ID        = 8'hfe;
  localparam logic [7:0]  CMD_PART_ID         = 8'hff;
  localparam logic [15:0] OPTION_RESET        = 16'h7904;
  localparam logic [15:0] CHG_CURRENT_RESET   = 16'h0000;
  localparam logic [15:0] CHG_VOLTAGE_RESET   = 16'h0000;
  localparam logic [15:0] INPUT_CURRENT_RESET = 16'h1000;
  // Current setting: 7 bits at [12:6], 64 mA per step, 128 mA .. 8.128 A.
  localparam int          CHG_CURRENT_LSB     = 6;
  localparam int          CHG_CURRENT_MSB     = 12;
  localparam logic [15:0] CHG_CURRENT_MASK    = 16'h1fc0;
  localparam logic [15:0] CHG_CURRENT_MIN     = 16'h0080;
  localparam logic [15:0] CHG_CURRENT_MAX     = 16'h1fc0;
  localparam logic [15:0] CHG_VOLTAGE_MASK    = 16'h7ff0;
  localparam logic [15:0] INPUT_CURRENT_MASK  = 16'h1f80;
  localparam int          OPT_DEGLITCH_BIT    = 15;
  localparam int          OPT_WDOG_LSB        = 13;
  localparam int          OPT_INHIBIT_BIT     = 0;
  localparam longint      CLK_HZ              = 10000000;
  localparam longint      WDOG_44_S           = 44;
  localparam longint      WDOG_88_S           = 88;
  localparam longint      WDOG_175_S          = 175;
  localparam longint      WDOG_44_CYC         = WDOG_44_S * CLK_HZ;
  localparam longint      WDOG_88_CYC         = WDOG_88_S * CLK_HZ;
  localparam longint      WDOG_175_CYC        = WDOG_175_S * CLK_HZ;
  localparam longint      DEGLITCH_LONG_MS    = 1300;
  localparam longint      DEGLITCH_LONG_CYC   = DEGLITCH_LONG_MS * CLK_HZ / 1000;
  localparam longint      DEGLITCH_SHORT_US   = 50;
  localparam longint      DEGLITCH_SHORT_CYC  = DEGLITCH_SHORT_US * CLK_HZ / 1000000 - 1;
  // Host register map over APB (byte addresses).
  localparam logic [7:0]  HREG_CTRL           = 8'h00;
  localparam logic [7:0]  HREG_WDATA          = 8'h04;
  localparam logic [7:0]  HREG_STATUS         = 8'h08;
  localparam logic [7:0]  HREG_RDATA          = 8'h0c;
  localparam int          HOST_CLK_DIV        = 4;
endpackage

// [test/csr_link_sva.sv]
/*
  Checker for the two-wire link between the charger register slave and its host.
  Assumes pclk samples the wire and that a bit period lasts a few tens of pclk.
*/
module csr_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_ok,
  input wire logic adapter_detect_input,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_dev,
  input wire logic sda_oe_dev,
  input wire logic sda_oe_host
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_dev_no_clock; !scl_oe_dev; endproperty
  a_dev_no_clock: assert property (p_dev_no_clock) else $error("slave drove the clock line");
  property p_dev_sda_scl_low; $changed(sda_oe_dev) |-> !scl && !$past(scl); endproperty
  a_dev_sda_scl_low: assert property (p_dev_sda_scl_low) else $error("slave moved data with clock high");
  property p_quiet_off; !(supply_ok && adapter_detect_input) |-> !sda_oe_dev; endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("slave answered while disabled");
  property p_ack_hold; $rose(scl) && sda_oe_dev |-> sda_oe_dev until !scl; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("slave released data in clock high");
  property p_ack_bounded; $rose(scl) && sda_oe_dev |-> ##[1:32] !scl; endproperty
  a_ack_bounded: assert property (p_ack_bounded) else $error("clock pulse too long");
  property p_scl_low_bounded; $fell(scl) |-> ##[1:64] scl; endproperty
  a_scl_low_bounded: assert property (p_scl_low_bounded) else $error("clock low too long");
  property p_start_by_host; $fell(sda) && scl |-> sda_oe_host && !sda_oe_dev; endproperty
  a_start_by_host: assert property (p_start_by_host) else $error("start not made by master");
  property p_free_after_stop; $rose(sda) && scl |-> !sda_oe_dev [*4]; endproperty
  a_free_after_stop: assert property (p_free_after_stop) else $error("slave held bus after stop");
endmodule // csr_link_sva

// [test/test_charger_smbus_register_slave.sv]
/*
  Bench for the charger register slave driven through its host over APB.
  Assumes the host answers APB with no wait and reports busy in STATUS bit 0.
*/
module test_charger_smbus_register_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic supply_ok, adapter_detect_input, adapter_valid_flag, charge_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, rdw;
  logic [15:0] rd;
  int failures, checks_done, i;
  localparam logic [15:0] MAKER = 16'h5a01; // Arbitrary value.
  localparam logic [15:0] PART = 16'h00c3; // Arbitrary value.
  localparam logic [7:0] CMDS [5] = '{8'h12, 8'h3f, 8'h15, 8'h14, 8'hff};
  localparam logic [15:0] WVAL [5] = '{16'h1904, 16'h0a00, 16'h3110, 16'h0800, 16'h0000};
  csr_link_if link();
  csr_device #(.WDOG_44_CYC(200), .WDOG_88_CYC(400), .WDOG_175_CYC(800), .DEGLITCH_CYC(20),
    .MAKER_ID(MAKER), .PART_ID(PART)) csr_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .supply_ok(supply_ok), .adapter_detect_input(adapter_detect_input), .adapter_valid_flag(adapter_valid_flag),
    .charge_enable(charge_enable), .charger_option_control(), .charge_current_setting(),
    .charge_voltage_setting(), .input_current_setting());
  csr_host csr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  csr_link_sva csr_link_sva_inst (.pclk(pclk), .presetn(presetn), .supply_ok(supply_ok),
    .adapter_detect_input(adapter_detect_input), .scl(link.scl), .sda(link.sda), .scl_oe_dev(link.scl_oe_dev),
    .sda_oe_dev(link.sda_oe_dev), .sda_oe_host(link.sda_oe_host));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; pready is sampled at each edge of the access phase.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    // One idle cycle, so that a following call never drives psel twice in one time step.
    @(posedge pclk);
  endtask
  // A word transfer on the link; the busy poll is bounded only by the 80000-cycle bench timeout.
  task automatic xfer(input logic [7:0] cmd, input logic r, input logic [15:0] w);
    apb(1'b1, csr_pkg::HREG_WDATA, {16'h0, w}, st);
    apb(1'b1, csr_pkg::HREG_CTRL, {23'h0, r, cmd}, st);
    do apb(1'b0, csr_pkg::HREG_STATUS, 32'h0, st); while (st[0] !== 1'b0);
    apb(1'b0, csr_pkg::HREG_RDATA, 32'h0, rdw);
    rd = rdw[15:0];
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    supply_ok = 1'b1;
    adapter_detect_input = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(8'h12, 1'b1, 16'h0);
    check("nack while adapter low", 16'h1, {15'h0, st[2]});
    adapter_detect_input <= 1'b1;
    repeat (40) @(posedge pclk);
    check("adapter valid", 16'h1, {15'h0, adapter_valid_flag});
    for (i = 0; i < 5; i++) begin
      xfer(CMDS[i], 1'b1, 16'h0);
      check("reset value", i == 1 ? 16'h1000 : i == 4 ? PART : i == 0 ? 16'h7904 : 16'h0, rd);
    end
    xfer(8'hfe, 1'b1, 16'h0);
    check("maker identity", MAKER, rd);
    for (i = 0; i < 5; i++) xfer(CMDS[i], 1'b0, WVAL[i]);
    for (i = 0; i < 5; i++) begin
      xfer(CMDS[i], 1'b1, 16'h0);
      check("read back", i == 4 ? PART : WVAL[i], rd);
    end
    check("charge enabled", 16'h1, {15'h0, charge_enable});
    xfer(8'h12, 1'b0, 16'h1905);
    check("charge inhibited", 16'h0, {15'h0, charge_enable});
    xfer(8'h20, 1'b1, 16'h0);
    check("unknown command nack", 16'h1, {15'h0, st[2]});
    xfer(8'h12, 1'b0, 16'h3904);
    xfer(8'h14, 1'b0, 16'h0800);
    check("charge after write", 16'h1, {15'h0, charge_enable});
    repeat (250) @(posedge pclk);
    check("watchdog expired", 16'h0, {15'h0, charge_enable});
    xfer(8'h15, 1'b0, 16'h3110);
    check("charge resumed", 16'h1, {15'h0, charge_enable});
    for (i = 0; i < 2; i++) begin
      xfer(8'h14, 1'b0, i == 0 ? 16'h0040 : 16'h2000);
      check("charge stopped", 16'h0, {15'h0, charge_enable});
      xfer(8'h14, 1'b1, 16'h0);
      check("current cleared", 16'h0, rd);
    end
    xfer(8'h12, 1'b0, 16'h9904);
    adapter_detect_input <= 1'b0;
    repeat (4) @(posedge pclk);
    adapter_detect_input <= 1'b1;
    repeat (40) @(posedge pclk);
    check("short deglitch pending", 16'h0, {15'h0, adapter_valid_flag});
    repeat (500) @(posedge pclk);
    check("short deglitch done", 16'h1, {15'h0, adapter_valid_flag});
    test_done();
  end
endmodule // test_charger_smbus_register_slave
